/* src/grq_raw_irq.sv */
// raw pin interrupt status for pins 8 to 29 and first core enables for pins 0 to 7
//
// The AXI4-Lite register port was left to the implementer.
module grq_raw_irq (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [29:8] pin_level,
	input wire logic [31:0] low_bank_raw,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic first_core_irq,
	output logic irq_out
);
	grq_pkg::grq_main_st_t st_r;
	grq_pkg::grq_main_st_t st_nxt;
	logic wr_fire;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic rd_fire;
	logic [11:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;
	logic [21:0] pin_lvl;
	logic [21:0] edge_rise;
	logic [21:0] edge_fall;
	logic [21:0] clr_rise;
	logic [21:0] clr_fall;
	logic [87:0] raw;
	logic [31:0] raw1;
	logic [31:0] raw2;
	logic [31:0] raw3;
	logic [21:0] any_edge;
	logic [3:0] evt_set;
	logic evt_rd_clr;

	grq_axil_slave u_bus (
		.mclk(mclk),
		.rstn(rstn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_fire(wr_fire),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_fire(rd_fire),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	grq_pin_edge u_edge (
		.mclk(mclk),
		.rstn(rstn),
		.pin_in(pin_level),
		.level(pin_lvl),
		.rise(edge_rise),
		.fall(edge_fall)
	);

	for (genvar i = 0; i < grq_pkg::GRQ_NPIN; i++) begin : g_pin
		localparam int WI = i / grq_pkg::GRQ_PINS_PER_WORD;
		localparam int BASE = (i % grq_pkg::GRQ_PINS_PER_WORD) * grq_pkg::GRQ_GRP_W;
		localparam int LANE = (BASE + grq_pkg::GRQ_BIT_RISE) / 8;
		localparam logic [11:0] OFF = (WI == 0) ? grq_pkg::GRQ_OFF_RAW1 :
			(WI == 1) ? grq_pkg::GRQ_OFF_RAW2 : grq_pkg::GRQ_OFF_RAW3;
		logic sel;
		assign sel = wr_fire && (wr_addr == OFF) && wr_strb[LANE];
		assign clr_rise[i] = sel && wr_data[BASE + grq_pkg::GRQ_BIT_RISE]; // see [R1]
		assign clr_fall[i] = sel && wr_data[BASE + grq_pkg::GRQ_BIT_FALL]; // see [R2]
		assign raw[4 * i + grq_pkg::GRQ_BIT_RISE] = st_r.rise[i]; // see [R1]
		assign raw[4 * i + grq_pkg::GRQ_BIT_FALL] = st_r.fall[i]; // see [R2]
		assign raw[4 * i + grq_pkg::GRQ_BIT_LVL_HI] = pin_lvl[i]; // see [R3]
		assign raw[4 * i + grq_pkg::GRQ_BIT_LVL_LO] = ~pin_lvl[i]; // see [R4]
	end

	assign raw1 = raw[31:0]; // see [R5]
	assign raw2 = raw[63:32]; // see [R6]
	assign raw3 = {8'h00, raw[87:64]}; // see [R7] see [R8]
	assign any_edge = edge_rise | edge_fall;
	assign evt_rd_clr = rd_fire && (rd_addr == grq_pkg::GRQ_OFF_EVT_STAT);

	always_comb begin
		wr_ok = 1'b1;
		case (wr_addr)
			grq_pkg::GRQ_OFF_RAW1, grq_pkg::GRQ_OFF_RAW2, grq_pkg::GRQ_OFF_RAW3: wr_ok = 1'b1;
			grq_pkg::GRQ_OFF_ENA0, grq_pkg::GRQ_OFF_EVT_STAT, grq_pkg::GRQ_OFF_EVT_MASK: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always_comb begin
		rd_ok = 1'b1;
		rd_data = grq_pkg::GRQ_RST_WORD;
		case (rd_addr)
			grq_pkg::GRQ_OFF_RAW1: rd_data = raw1;
			grq_pkg::GRQ_OFF_RAW2: rd_data = raw2;
			grq_pkg::GRQ_OFF_RAW3: rd_data = raw3;
			grq_pkg::GRQ_OFF_ENA0: rd_data = st_r.enable;
			grq_pkg::GRQ_OFF_EVT_STAT: rd_data = {28'h0000000, st_r.evt};
			grq_pkg::GRQ_OFF_EVT_MASK: rd_data = {28'h0000000, st_r.mask};
			default: rd_ok = 1'b0;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		// set wins over a clear in the same cycle so no edge is lost
		st_nxt.rise = (st_r.rise & ~clr_rise) | edge_rise; // see [R1]
		st_nxt.fall = (st_r.fall & ~clr_fall) | edge_fall; // see [R2]
		if (wr_fire && (wr_addr == grq_pkg::GRQ_OFF_ENA0)) begin
			for (int b = 0; b < 4; b++) begin
				if (wr_strb[b]) begin
					st_nxt.enable[8 * b +: 8] = wr_data[8 * b +: 8]; // see [R9] see [R10]
				end
			end
		end
		if (wr_fire && (wr_addr == grq_pkg::GRQ_OFF_EVT_MASK) && wr_strb[0]) begin
			st_nxt.mask = wr_data[3:0];
		end
		st_nxt.core_irq = |(low_bank_raw & st_r.enable); // see [R11]
		evt_set = '0;
		evt_set[grq_pkg::GRQ_EVT_W1] = |any_edge[7:0];
		evt_set[grq_pkg::GRQ_EVT_W2] = |any_edge[15:8];
		evt_set[grq_pkg::GRQ_EVT_W3] = |any_edge[21:16];
		evt_set[grq_pkg::GRQ_EVT_CORE] = st_nxt.core_irq && !st_r.core_irq;
		// a read clears only what it returned; a new event still lands
		st_nxt.evt = (evt_rd_clr ? grq_pkg::GRQ_RST_EVT : st_r.evt) | evt_set;
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign first_core_irq = st_r.core_irq;
	assign irq_out = |(st_r.evt & st_r.mask);

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	sequence s_ena_full_write;
		wr_fire && (wr_addr == grq_pkg::GRQ_OFF_ENA0) && (wr_strb == 4'hF);
	endsequence

	sequence s_raw3_read;
		rd_fire && (rd_addr == grq_pkg::GRQ_OFF_RAW3);
	endsequence

	AST_RISE_STICKS: assert property ( // see [R1]
		(edge_rise != '0) |=> ((st_r.rise & $past(edge_rise)) == $past(edge_rise)) [*2])
		else $error("rising edge flag not held");
	AST_FALL_STICKS: assert property ( // see [R2]
		(edge_fall != '0) |=> ((st_r.fall & $past(edge_fall)) == $past(edge_fall)))
		else $error("falling edge flag not set");
	AST_RISE_CLEAR: assert property ( // see [R1]
		(clr_rise[0] && !edge_rise[0]) |=> !raw1[grq_pkg::GRQ_BIT_RISE])
		else $error("write one did not clear pin 8 rise flag");
	AST_LEVEL_HIGH: assert property ( // see [R3]
		pin_level[8] |=> raw1[grq_pkg::GRQ_BIT_LVL_HI] && !raw1[grq_pkg::GRQ_BIT_LVL_LO])
		else $error("pin 8 high level not shown");
	AST_LEVEL_LOW: assert property ( // see [R4]
		!pin_level[29] |=> raw3[23 - 3] && !raw3[23 - 2])
		else $error("pin 29 low level not shown");
	AST_RAW1_READ: assert property ( // see [R5]
		(rd_fire && (rd_addr == grq_pkg::GRQ_OFF_RAW1)) |=> s_axi_rvalid && (s_axi_rdata == $past(raw1)))
		else $error("raw word one read data wrong");
	AST_RAW3_RSVD: assert property ( // see [R8]
		s_raw3_read |=> s_axi_rvalid && (s_axi_rdata[31:24] == 8'h00) && (s_axi_rdata[23] == $past(st_r.rise[21])))
		else $error("raw word three upper bits not zero");
	AST_ENA_WRITE: assert property ( // see [R9]
		s_ena_full_write |=> (st_r.enable == $past(wr_data)) && s_axi_bvalid)
		else $error("enable word did not take write data");
	AST_CORE_IRQ: assert property ( // see [R11]
		((low_bank_raw & st_r.enable) != '0) |=> first_core_irq)
		else $error("first core interrupt missing");
	AST_EVT_IRQ: assert property (
		($rose(first_core_irq) && st_r.mask[grq_pkg::GRQ_EVT_CORE]) |-> irq_out)
		else $error("event interrupt not raised");
endmodule : grq_raw_irq

/* src/grq_pkg.sv */
// constants and state types for the raw pin interrupt status block
// Functional notes
// [R1] per pin, top bit of its group is a sticky rising-edge flag, write one clears
// [R2] per pin, second-highest bit is a sticky falling-edge flag, write one clears
// [R3] per pin, second-lowest bit shows the live high level, read only
// [R4] per pin, lowest bit shows the live low level, read only
// [R5] raw word at 0x0F4 holds pins 8 to 15, four bits each, pin 8 lowest
// [R6] raw word at 0x0F8 holds pins 16 to 23, pin 16 lowest
// [R7] raw word at 0x0FC holds pins 24 to 29, pin 29 rise flag at bit 23
// [R8] bits 31:24 of the last raw word read zero and ignore writes
// [R9] enable word for the first core at 0x100, read-write, resets to zero
// [R10] enable word covers pins 0 to 7, same four-bit order, pin 0 rise at bit 3
// [R11] first core interrupt is high while any raw bit and its enable are both set
package grq_pkg;
	localparam int GRQ_AW = 12;
	localparam int GRQ_DW = 32;
	localparam int GRQ_NPIN = 22;
	localparam int GRQ_PINS_PER_WORD = 8;
	localparam int GRQ_GRP_W = 4;
	localparam int GRQ_RAW_W = 88;
	localparam int GRQ_BIT_RISE = 3;
	localparam int GRQ_BIT_FALL = 2;
	localparam int GRQ_BIT_LVL_HI = 1;
	localparam int GRQ_BIT_LVL_LO = 0;
	localparam int GRQ_RSVD_LO = 24;
	localparam logic [11:0] GRQ_OFF_RAW1 = 12'h0F4;
	localparam logic [11:0] GRQ_OFF_RAW2 = 12'h0F8;
	localparam logic [11:0] GRQ_OFF_RAW3 = 12'h0FC;
	localparam logic [11:0] GRQ_OFF_ENA0 = 12'h100;
	localparam logic [11:0] GRQ_OFF_EVT_STAT = 12'h120;
	localparam logic [11:0] GRQ_OFF_EVT_MASK = 12'h124;
	localparam logic [31:0] GRQ_RST_WORD = 32'h0;
	localparam int GRQ_NEVT = 4;
	localparam logic [3:0] GRQ_RST_EVT = 4'h0;
	localparam int GRQ_EVT_W1 = 0;
	localparam int GRQ_EVT_W2 = 1;
	localparam int GRQ_EVT_W3 = 2;
	localparam int GRQ_EVT_CORE = 3;
	localparam logic [1:0] GRQ_RESP_OKAY = 2'h0;
	localparam logic [1:0] GRQ_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic aw_full;
		logic [11:0] awaddr;
		logic w_full;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} grq_axil_st_t;

	typedef struct packed {
		logic [21:0] lvl;
		logic [21:0] prev;
	} grq_edge_st_t;

	typedef struct packed {
		logic [21:0] rise;
		logic [21:0] fall;
		logic [31:0] enable;
		logic [3:0] evt;
		logic [3:0] mask;
		logic core_irq;
	} grq_main_st_t;
endpackage : grq_pkg

/* src/grq_pin_edge.sv */
// pin level sampling and one-cycle edge pulses
module grq_pin_edge (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [21:0] pin_in,
	output logic [21:0] level,
	output logic [21:0] rise,
	output logic [21:0] fall
);
	grq_pkg::grq_edge_st_t st_r;
	grq_pkg::grq_edge_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.prev = st_r.lvl;
		st_nxt.lvl = pin_in;
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// a pin high at reset release shows one rise: prev starts low
	assign level = st_r.lvl;
	assign rise = st_r.lvl & ~st_r.prev;
	assign fall = ~st_r.lvl & st_r.prev;
endmodule : grq_pin_edge

/* src/grq_axil_slave.sv */
// axi4-lite slave front end, one write and one read at a time
module grq_axil_slave (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_fire,
	output logic [11:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic rd_fire,
	output logic [11:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);
	grq_pkg::grq_axil_st_t st_r;
	grq_pkg::grq_axil_st_t st_nxt;

	// no new address or data while a response waits, so one write at a time
	assign s_axi_awready = !st_r.aw_full && !st_r.bvalid;
	assign s_axi_wready = !st_r.w_full && !st_r.bvalid;
	assign s_axi_arready = !st_r.rvalid;
	assign wr_fire = st_r.aw_full && st_r.w_full && !st_r.bvalid;
	assign wr_addr = st_r.awaddr;
	assign wr_data = st_r.wdata;
	assign wr_strb = st_r.wstrb;
	assign rd_fire = s_axi_arvalid && !st_r.rvalid;
	assign rd_addr = s_axi_araddr;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;

	always_comb begin
		st_nxt = st_r;
		if (s_axi_awvalid && s_axi_awready) begin
			st_nxt.aw_full = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_nxt.w_full = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
		end
		if (wr_fire) begin
			st_nxt.aw_full = 1'b0;
			st_nxt.w_full = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = wr_ok ? grq_pkg::GRQ_RESP_OKAY : grq_pkg::GRQ_RESP_SLVERR;
		end else if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (rd_fire) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rd_ok ? rd_data : grq_pkg::GRQ_RST_WORD;
			st_nxt.rresp = rd_ok ? grq_pkg::GRQ_RESP_OKAY : grq_pkg::GRQ_RESP_SLVERR;
		end else if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : grq_axil_slave

/* sim/grq_core_model.sv */
// processor core model: axi4-lite master that reads and writes the block
module grq_core_model (
	input logic mclk,
	output logic [11:0] awaddr,
	output logic awvalid,
	input logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input logic wready,
	input logic [1:0] bresp,
	input logic bvalid,
	output logic bready,
	output logic [11:0] araddr,
	output logic arvalid,
	input logic arready,
	input logic [31:0] rdata,
	input logic [1:0] rresp,
	input logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// handshakes judged on the values standing at each rising edge, as the slave samples them
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ah, wh, bh;
		@(posedge mclk);
		awaddr <= a;
		awvalid <= 1'h1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'h1;
		bready <= 1'h1;
		ah = 1'h1;
		wh = 1'h1;
		bh = 1'h0;
		while (!bh) begin
			@(posedge mclk);
			bh = bvalid;
			r = bresp;
			if (ah && awready) begin
				ah = 1'h0;
				awvalid <= 1'h0;
				awaddr <= ~a;
			end
			if (wh && wready) begin
				wh = 1'h0;
				wvalid <= 1'h0;
				wdata <= ~d;
			end
		end
		bready <= 1'h0;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ah, rh;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		ah = 1'h1;
		rh = 1'h0;
		while (!rh) begin
			@(posedge mclk);
			rh = rvalid;
			d = rdata;
			r = rresp;
			if (ah && arready) begin
				ah = 1'h0;
				arvalid <= 1'h0;
				araddr <= ~a;
			end
		end
		rready <= 1'h0;
	endtask : rd
endmodule : grq_core_model

/* sim/grq_raw_irq_tb.sv */
// self-checking bench for the raw pin interrupt status block
module grq_raw_irq_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rstn, awv, awr, wv, wr_, bv, br, arv, arr, rv_, rr, cirq, irq;
	logic [29:8] pins;
	logic [31:0] lowraw, wd, rd_, rv;
	logic [11:0] awa, ara;
	logic [3:0] ws;
	logic [1:0] bre, rre, rs;
	int miscompares = 0;
	int total_checks = 0;
	grq_raw_irq dut_u (.mclk(mclk), .rstn(rstn), .pin_level(pins), .low_bank_raw(lowraw),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bre),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd_), .s_axi_rresp(rre), .s_axi_rvalid(rv_),
		.s_axi_rready(rr), .first_core_irq(cirq), .irq_out(irq));
	grq_core_model core_u (.mclk(mclk), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wd),
		.wstrb(ws), .wvalid(wv), .wready(wr_), .bresp(bre), .bvalid(bv), .bready(br), .araddr(ara),
		.arvalid(arv), .arready(arr), .rdata(rd_), .rresp(rre), .rvalid(rv_), .rready(rr));
	initial begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end
	task automatic end_of_test();
		if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		core_u.rd(a, rv, rs);
		chk($sformatf("rdata %h", a), e, rv);
		chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rs});
	endtask : rchk
	task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		core_u.wr(a, d, rs);
		chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, rs});
	endtask : wchk
	task automatic waitc(input int n);
		repeat (n) @(posedge mclk);
	endtask : waitc
	localparam logic [1:0] OK = grq_pkg::GRQ_RESP_OKAY;
	initial begin
		repeat (5000) @(posedge mclk);
		miscompares++;
		end_of_test();
	end
	initial begin
		rstn = 1'h0;
		pins = '0;
		lowraw = '0;
		waitc(16);
		rstn <= 1'h1;
		waitc(4);
		chk("irq_out", 32'h0, {31'h0, irq});
		rchk(grq_pkg::GRQ_OFF_RAW1, 32'h11111111, OK);
		rchk(grq_pkg::GRQ_OFF_RAW2, 32'h11111111, OK);
		rchk(grq_pkg::GRQ_OFF_RAW3, 32'h00111111, OK);
		rchk(grq_pkg::GRQ_OFF_ENA0, 32'h0, OK);
		pins <= '1;
		waitc(4);
		rchk(grq_pkg::GRQ_OFF_RAW1, 32'hAAAAAAAA, OK);
		rchk(grq_pkg::GRQ_OFF_RAW3, 32'h00AAAAAA, OK);
		pins <= '0;
		waitc(4);
		rchk(grq_pkg::GRQ_OFF_RAW2, 32'hDDDDDDDD, OK);
		// clear only one flag kind in each of the first two words so a swapped bit shows; the third word clears both
		wchk(grq_pkg::GRQ_OFF_RAW1, 32'h88888888, OK);
		rchk(grq_pkg::GRQ_OFF_RAW1, 32'h55555555, OK);
		wchk(grq_pkg::GRQ_OFF_RAW2, 32'h44444444, OK);
		rchk(grq_pkg::GRQ_OFF_RAW2, 32'h99999999, OK);
		wchk(grq_pkg::GRQ_OFF_RAW3, 32'hFFFFFFFF, OK);
		rchk(grq_pkg::GRQ_OFF_RAW3, 32'h00111111, OK);
		wchk(grq_pkg::GRQ_OFF_ENA0, 32'hFFFFFFFF, OK);
		rchk(grq_pkg::GRQ_OFF_ENA0, 32'hFFFFFFFF, OK);
		wchk(grq_pkg::GRQ_OFF_ENA0, 32'h00000008, OK);
		lowraw <= 32'h00000004;
		waitc(4);
		chk("first_core_irq", 32'h0, {31'h0, cirq});
		lowraw <= 32'h00000008;
		waitc(4);
		chk("first_core_irq", 32'h1, {31'h0, cirq});
		wchk(grq_pkg::GRQ_OFF_ENA0, 32'h0, OK);
		waitc(3);
		chk("first_core_irq", 32'h0, {31'h0, cirq});
		wchk(grq_pkg::GRQ_OFF_EVT_MASK, 32'h1, OK);
		// edges in all three words and the core rise so far, all four events
		rchk(grq_pkg::GRQ_OFF_EVT_STAT, 32'hF, OK);
		waitc(2);
		chk("irq_out", 32'h0, {31'h0, irq});
		pins[8] <= 1'h1;
		waitc(4);
		chk("irq_out", 32'h1, {31'h0, irq});
		rchk(grq_pkg::GRQ_OFF_EVT_STAT, 32'h1, OK);
		waitc(2);
		chk("irq_out", 32'h0, {31'h0, irq});
		wchk(grq_pkg::GRQ_OFF_EVT_MASK, 32'h8, OK);
		rchk(grq_pkg::GRQ_OFF_EVT_MASK, 32'h8, OK);
		chk("irq_out", 32'h0, {31'h0, irq});
		wchk(grq_pkg::GRQ_OFF_ENA0, 32'h00000008, OK);
		waitc(3);
		chk("first_core_irq", 32'h1, {31'h0, cirq});
		chk("irq_out", 32'h1, {31'h0, irq});
		rchk(grq_pkg::GRQ_OFF_EVT_STAT, 32'h8, OK);
		waitc(2);
		chk("irq_out", 32'h0, {31'h0, irq});
		rchk(12'h104, 32'h0, grq_pkg::GRQ_RESP_SLVERR);
		wchk(12'h104, 32'hFFFFFFFF, grq_pkg::GRQ_RESP_SLVERR);
		end_of_test();
	end
endmodule : grq_raw_irq_tb
